// *** src/hrc_pkg.sv ***
// Package: register map, field layout and timing constants for hook release
package hrc_pkg;
  // Register address on the serial control port
  localparam logic [6:0] HRC_REG_ADDR   = 7'h3b;
  localparam int         HRC_ADDR_W     = 7;
  localparam int         HRC_DATA_W     = 8;
  // Field positions inside the control register
  localparam int         HRC_SQ_HI_BIT  = 6;
  localparam int         HRC_SQ_LO_BIT  = 4;
  localparam int         HRC_RG_BIT     = 2;
  localparam int         HRC_GCE_BIT    = 1;
  // Read-write bits; the rest are reserved and read as zero
  localparam logic [7:0] HRC_RW_MASK    = 8'h56;
  localparam logic [7:0] HRC_RESET_VAL  = 8'h00;
  // Serial frame: read flag, 7-bit address, 8-bit data
  localparam int         HRC_FRAME_BITS = 16;
  localparam int         HRC_HDR_BITS   = 8;
  localparam logic [4:0] HRC_CNT_HDR    = 5'h08;
  localparam logic [4:0] HRC_CNT_LAST   = 5'h0f;
  // Release timing
  localparam int         HRC_CLK_MHZ    = 250;
  localparam int         HRC_ETSI_US    = 3000;
  localparam int         HRC_QUENCH_US  = 26000;
  localparam int         HRC_ETSI_CYC   = HRC_ETSI_US * HRC_CLK_MHZ;
  localparam int         HRC_QUENCH_CYC = HRC_QUENCH_US * HRC_CLK_MHZ;
  // Fast release must stay under 0.5 ms; a single cycle does
  localparam int         HRC_FAST_CYC   = 1;
  localparam int         HRC_TMR_W      = 23;
endpackage

// *** src/hrc_reg_if.sv ***
// Interface: register access between serial port slave and control register
`timescale 1ns/1ps
`default_nettype none
interface hrc_reg_if;
  import hrc_pkg::*;
  logic [HRC_ADDR_W-1:0] addr;
  logic [HRC_DATA_W-1:0] wdata;
  logic                  wr_en;
  logic [HRC_DATA_W-1:0] rdata;
  modport port_side (output addr, output wdata, output wr_en, input rdata);
  modport reg_side  (input addr, input wdata, input wr_en, output rdata);
endinterface
`default_nettype wire

// *** src/hrc_spi_slave.sv ***
// Serial control port slave: frames 16-bit accesses onto the register link
`timescale 1ns/1ps
`default_nettype none
module hrc_spi_slave
  import hrc_pkg::*;
(
  input  wire logic     i_clock,
  input  wire logic     i_rst_n,
  input  wire logic     i_cs_n,
  input  wire logic     i_sclk,
  input  wire logic     i_sdi,
  output var  logic     o_sdo,
  output var  logic     o_sdo_oe,
  hrc_reg_if.port_side  reg_bus
);
  logic [1:0]  cs_sync_q;
  logic [2:0]  sclk_sync_q;
  logic [1:0]  sdi_sync_q;
  logic [4:0]  bit_cnt_q;
  logic [14:0] shift_q;
  logic [7:0]  rd_shift_q;
  logic        rd_load_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_active;

  ////////////////////////////////////////////////////////////////////////////
  // Pins are asynchronous to i_clock; only stage two onward is looked at
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_sync_q   <= 2'h3;
      sclk_sync_q <= 3'h0;
      sdi_sync_q  <= 2'h0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], i_cs_n};
      sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
      sdi_sync_q  <= {sdi_sync_q[0], i_sdi};
    end
  end

  assign cs_active = !cs_sync_q[1];
  assign sclk_rise = cs_active && sclk_sync_q[1] && !sclk_sync_q[2];
  assign sclk_fall = cs_active && !sclk_sync_q[1] && sclk_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifter; a frame cut short by chip select is dropped
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_q     <= 5'h00;
      shift_q       <= 15'h0000;
      reg_bus.wr_en <= 1'b0;
      reg_bus.addr  <= 7'h00;
      reg_bus.wdata <= 8'h00;
    end else begin
      reg_bus.wr_en <= 1'b0;
      if (!cs_active) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        shift_q   <= {shift_q[13:0], sdi_sync_q[1]};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == HRC_CNT_HDR - 5'h01) begin
          reg_bus.addr <= {shift_q[5:0], sdi_sync_q[1]};
        end
        if (bit_cnt_q == HRC_CNT_LAST && !shift_q[14]) begin
          reg_bus.wdata <= {shift_q[6:0], sdi_sync_q[1]};
          reg_bus.wr_en <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data leaves MSB first, changing on falling clock edges
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_shift_q <= 8'h00;
      o_sdo      <= 1'b0;
      o_sdo_oe   <= 1'b0;
      rd_load_q  <= 1'b0;
    end else begin
      rd_load_q <= 1'b0;
      if (!cs_active) begin
        o_sdo_oe <= 1'b0;
      end else if (sclk_rise && bit_cnt_q == HRC_CNT_HDR - 5'h01) begin
        // The header's first bit flags a read; the address lands this edge
        o_sdo_oe  <= shift_q[6];
        rd_load_q <= 1'b1;
      end else if (rd_load_q) begin
        // One clock late so read data follows the new address, not the old
        o_sdo      <= reg_bus.rdata[7];
        rd_shift_q <= {reg_bus.rdata[6:0], 1'b0};
      end else if (sclk_fall && bit_cnt_q > HRC_CNT_HDR) begin
        o_sdo      <= rd_shift_q[7];
        rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
    end
  end
endmodule // hrc_spi_slave
`default_nettype wire

// *** src/hrc_hook_release_control.sv ***
// Hook release control register and on-hook release timer
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Release speed is chosen from the spark-quench field, hook speed select and its extension.
// - The release interval runs from the off-hook request falling until loop current is dropped.
// - All mode bits zero gives a release well under 0.5 ms.
// - Speed select 0, extension 1, field 00 gives a 3 ms release.
// - Speed select 1 with field 11 gives a 26 ms release, whatever the extension holds.
// - The receive gain boost bit adds 1 dB of hybrid gain when set.
// - Guarded clear draws on-hook line current only when it and its companion bit are both set.
// - Register content is not guaranteed after reset; software must program every field.
module hrc_hook_release_control
  import hrc_pkg::*;
#(
  parameter int P_ETSI_CYC   = HRC_ETSI_CYC,
  parameter int P_QUENCH_CYC = HRC_QUENCH_CYC
) (
  input  wire logic  i_clock,
  input  wire logic  i_rst_n,
  input  wire logic  i_cs_n,
  input  wire logic  i_sclk,
  input  wire logic  i_sdi,
  output var  logic  o_sdo,
  output var  logic  o_sdo_oe,
  input  wire logic  i_off_hook_request,
  input  wire logic  i_hook_speed_sel,
  input  wire logic  i_hook_speed_ext,
  input  wire logic  i_guard_companion_bit,
  output var  logic  o_loop_closed,
  output var  logic  o_release_busy,
  output var  logic  o_rx_gain_boost,
  output var  logic  o_guard_current_en
);
  hrc_reg_if reg_bus ();

  logic [7:0]           ctrl_q;
  logic [1:0]           spark_quench_field;
  logic                 off_hook_prev_q;
  logic [HRC_TMR_W-1:0] release_tmr_q;

  hrc_spi_slave u_port (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_cs_n   (i_cs_n),
    .i_sclk   (i_sclk),
    .i_sdi    (i_sdi),
    .o_sdo    (o_sdo),
    .o_sdo_oe (o_sdo_oe),
    .reg_bus  (reg_bus.port_side)
  );

  // Picks the release time in cycles; unlisted combinations release fast
  function automatic logic [HRC_TMR_W-1:0] release_cycles(
    input logic       speed_sel,
    input logic       speed_ext,
    input logic [1:0] sq);
    logic [HRC_TMR_W-1:0] cyc;
    cyc = HRC_TMR_W'(HRC_FAST_CYC);
    if (speed_sel && sq == 2'h3) begin
      cyc = HRC_TMR_W'(P_QUENCH_CYC);
    end else if (!speed_sel && speed_ext && sq == 2'h0) begin
      cyc = HRC_TMR_W'(P_ETSI_CYC);
    end
    return cyc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control register; reset value is a convenience, not a promise to software
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= HRC_RESET_VAL;
    end else if (reg_bus.wr_en && reg_bus.addr == HRC_REG_ADDR) begin
      ctrl_q <= reg_bus.wdata & HRC_RW_MASK;
    end
  end

  // Unmapped addresses read zero
  assign reg_bus.rdata = (reg_bus.addr == HRC_REG_ADDR) ? ctrl_q : 8'h00;
  assign spark_quench_field = {ctrl_q[HRC_SQ_HI_BIT], ctrl_q[HRC_SQ_LO_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // Release timer: mode is sampled once at the request's falling edge
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      off_hook_prev_q <= 1'b0;
      release_tmr_q   <= '0;
      o_loop_closed   <= 1'b0;
      o_release_busy  <= 1'b0;
    end else begin
      off_hook_prev_q <= i_off_hook_request;
      if (i_off_hook_request) begin
        // A new request aborts any release under way
        o_loop_closed  <= 1'b1;
        o_release_busy <= 1'b0;
        release_tmr_q  <= '0;
      end else if (off_hook_prev_q) begin
        release_tmr_q  <= release_cycles(i_hook_speed_sel, i_hook_speed_ext,
                                         spark_quench_field);
        o_release_busy <= 1'b1;
      end else if (o_release_busy) begin
        if (release_tmr_q <= HRC_TMR_W'(1)) begin
          o_loop_closed  <= 1'b0;
          o_release_busy <= 1'b0;
          release_tmr_q  <= '0;
        end else begin
          release_tmr_q <= release_tmr_q - HRC_TMR_W'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line-side controls follow the stored fields one cycle after a write
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_gain_boost    <= 1'b0;
      o_guard_current_en <= 1'b0;
    end else begin
      o_rx_gain_boost    <= ctrl_q[HRC_RG_BIT];
      o_guard_current_en <= ctrl_q[HRC_GCE_BIT] && i_guard_companion_bit
                            && !i_off_hook_request && !o_loop_closed;
    end
  end
endmodule // hrc_hook_release_control
`default_nettype wire

// *** tb/hrc_hook_release_control_assertions.sv ***
// Checker: port-level properties of the hook release control block
`timescale 1ns/1ps
`default_nettype none
module hrc_hook_release_control_assertions #(
  parameter int P_ETSI_CYC   = 20,
  parameter int P_QUENCH_CYC = 50
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_off_hook_request,
  input wire logic i_hook_speed_sel,
  input wire logic i_hook_speed_ext,
  input wire logic i_guard_companion_bit,
  input wire logic o_loop_closed,
  input wire logic o_release_busy,
  input wire logic o_rx_gain_boost,
  input wire logic o_guard_current_en,
  input wire logic o_sdo_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence off_hook_held;
    i_off_hook_request [*3];
  endsequence
  // Speed select and extension both clear must release fast, whatever the field holds
  sequence fast_drop;
    ##[1:4] !o_loop_closed;
  endsequence
  loop_held_a: assert property (off_hook_held |-> o_loop_closed)
    else $error("loop open while off-hook held");
  fast_release_a: assert property ($fell(i_off_hook_request)
    && !i_hook_speed_sel && !i_hook_speed_ext |-> fast_drop)
    else $error("fast release too slow");
  open_on_hook_a: assert property ($fell(o_loop_closed)
    |-> !$past(i_off_hook_request)) else $error("loop opened while off-hook");
  close_cause_a: assert property ($rose(o_loop_closed)
    |-> $past(i_off_hook_request)) else $error("loop closed uncalled");
  busy_closed_a: assert property (o_release_busy |-> o_loop_closed)
    else $error("release busy with loop open");
  guard_gate_a: assert property (o_guard_current_en
    |-> $past(i_guard_companion_bit) && !o_loop_closed)
    else $error("guard current without companion or on-hook");
  guard_drop_a: assert property ($fell(i_guard_companion_bit)
    |-> ##1 !o_guard_current_en) else $error("guard current stuck");
  sdo_idle_a: assert property (i_cs_n [*8] |-> !o_sdo_oe)
    else $error("serial output driven while deselected");
  gain_steady_a: assert property (i_cs_n [*8]
    |-> $stable(o_rx_gain_boost)) else $error("gain moved without write");
endmodule // hrc_hook_release_control_assertions
`default_nettype wire

// *** tb/hrc_hook_release_control_tb_top.sv ***
// Testbench: serial register access and release timing of hook release
`timescale 1ns/1ps
`default_nettype none
module hrc_hook_release_control_tb_top;
  import hrc_pkg::*;
  localparam int P_ETSI_CYC   = 20;
  localparam int P_QUENCH_CYC = 50;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_cs_n = 1'b1, i_sclk = 1'b0;
  logic i_sdi = 1'b0, i_off_hook_request = 1'b0, i_hook_speed_sel = 1'b0;
  logic i_hook_speed_ext = 1'b0, i_guard_companion_bit = 1'b1;
  logic o_sdo, o_sdo_oe, o_loop_closed, o_release_busy, o_rx_gain_boost;
  logic o_guard_current_en, oe;
  logic [7:0] rd;
  int n_errors = 0, cmp_count = 0, n;
  always #2 i_clock = ~i_clock;
  hrc_hook_release_control #(.P_ETSI_CYC(P_ETSI_CYC),
    .P_QUENCH_CYC(P_QUENCH_CYC)) u_hrc_hook_release_control (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
    .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .i_off_hook_request(i_off_hook_request),
    .i_hook_speed_sel(i_hook_speed_sel), .i_hook_speed_ext(i_hook_speed_ext),
    .i_guard_companion_bit(i_guard_companion_bit),
    .o_loop_closed(o_loop_closed), .o_release_busy(o_release_busy),
    .o_rx_gain_boost(o_rx_gain_boost),
    .o_guard_current_en(o_guard_current_en));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({7'h00, got}, {7'h00, exp});
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge i_clock);
  endtask
  // Half period of 5 clocks keeps above the 4-clock sync minimum
  task automatic xfer(input logic [15:0] f);
    i_cs_n = 1'b0;
    tick(5);
    for (int i = 15; i >= 0; i--) begin
      i_sdi = f[i];
      tick(5);
      if (i < 8) rd[i] = o_sdo;
      if (i == 0) oe = o_sdo_oe;
      i_sclk = 1'b1;
      tick(5);
      i_sclk = 1'b0;
    end
    tick(5);
    i_cs_n = 1'b1;
    tick(8);
    cmp_bit(oe, f[15]);
  endtask
  task automatic hang_up(input logic s, e, input logic [1:0] q,
                         input logic g, input int nexp);
    xfer({8'h3b, 1'b0, q[1], 1'b0, q[0], 2'b00, g, 1'b0});
    i_hook_speed_sel = s;
    i_hook_speed_ext = e;
    i_off_hook_request = 1'b1;
    tick(6);
    cmp_bit(o_loop_closed, 1'b1);
    i_off_hook_request = 1'b0;
    tick(1);
    cmp_bit(o_release_busy, 1'b1);
    n = 1;
    while (o_loop_closed === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    cmp_bit(n >= nexp && n <= nexp + 4, 1'b1);
    cmp_bit(o_release_busy, 1'b0);
    tick(3);
    cmp_bit(o_guard_current_en, g);
  endtask
  task automatic results;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    i_rst_n = 1'b1;
    cmp_bit(o_loop_closed, 1'b0);
    tick(3);
    xfer(16'h3b56);
    cmp_bit(o_rx_gain_boost, 1'b1);
    xfer(16'h1000);
    xfer(16'hbb00);
    cmp(rd, 8'h56);
    xfer(16'h9000);
    cmp(rd, 8'h00);
    xfer(16'h3b00);
    cmp_bit(o_rx_gain_boost, 1'b0);
    hang_up(1'b0, 1'b0, 2'b00, 1'b0, HRC_FAST_CYC);
    hang_up(1'b0, 1'b1, 2'b00, 1'b1, P_ETSI_CYC);
    hang_up(1'b1, 1'b0, 2'b11, 1'b1, P_QUENCH_CYC);
    hang_up(1'b1, 1'b1, 2'b11, 1'b0, P_QUENCH_CYC);
    // Going off-hook again mid-release must keep the loop closed
    i_off_hook_request = 1'b1;
    tick(6);
    i_off_hook_request = 1'b0;
    tick(10);
    i_off_hook_request = 1'b1;
    tick(P_QUENCH_CYC);
    cmp_bit(o_loop_closed, 1'b1);
    hang_up(1'b1, 1'b0, 2'b01, 1'b1, HRC_FAST_CYC);
    // Guard current must follow the companion bit while on-hook
    i_guard_companion_bit = 1'b0;
    tick(2);
    cmp_bit(o_guard_current_en, 1'b0);
    i_guard_companion_bit = 1'b1;
    tick(2);
    cmp_bit(o_guard_current_en, 1'b1);
    xfer(16'hbb00);
    cmp(rd, 8'h12);
    results;
  end
  initial begin
    tick(30000);
    n_errors++;
    results;
  end
endmodule // hrc_hook_release_control_tb_top
bind hrc_hook_release_control hrc_hook_release_control_assertions #(
  .P_ETSI_CYC(P_ETSI_CYC), .P_QUENCH_CYC(P_QUENCH_CYC)) u_chk (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
  .i_off_hook_request(i_off_hook_request),
  .i_hook_speed_sel(i_hook_speed_sel), .i_hook_speed_ext(i_hook_speed_ext),
  .i_guard_companion_bit(i_guard_companion_bit),
  .o_loop_closed(o_loop_closed), .o_release_busy(o_release_busy),
  .o_rx_gain_boost(o_rx_gain_boost),
  .o_guard_current_en(o_guard_current_en), .o_sdo_oe(o_sdo_oe));
`default_nettype wire
